/* csaah_host.sv */
// Host model issuing dword configuration requests.
// Assumes the block acks at the taking edge, in time for the next falling edge.
`timescale 1ns/1ns
module csaah_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdata_i,
  output logic req_o,
  output logic we_o,
  output logic [11:0] addr_o,
  output logic [3:0] be_o,
  output logic [31:0] wdata_o
);
  initial {req_o, we_o, addr_o, be_o, wdata_o} = '0;
  // Flags are cleared by writing ones; vendor space is written only when a test asks
  task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d,
    output logic [31:0] q);
    @(negedge clk_i);
    {req_o, we_o, addr_o, be_o, wdata_o} = {1'b1, w, a, b, d};
    @(negedge clk_i);
    q = ack_i ? rdata_i : 32'hx;
    // Released we, address and data lines flip and req drops, so stale values cannot pass for live ones; be_o holds
    {req_o, we_o, addr_o, wdata_o} = {1'b0, ~w, ~a, ~d};
  endtask
endmodule // csaah_host

/* csaah_pkg.sv */
// Package for the configuration-space arbiter status and error header block.
// Holds byte offsets, field positions, reset values and fixed codes.
package csaah_pkg;
  localparam int unsigned CSAAH_ADDR_W = 12;
  localparam logic [11:0] CSAAH_OFS_ARB_FLAGS = 12'h0de;
  localparam logic [11:0] CSAAH_OFS_VRSV_A = 12'h0e0;
  localparam logic [11:0] CSAAH_OFS_VRSV_B = 12'h0e2;
  localparam logic [11:0] CSAAH_OFS_VRSV_C = 12'h0e4;
  localparam logic [11:0] CSAAH_OFS_CAP_ID = 12'h100;
  localparam logic [11:0] CSAAH_OFS_NEXT_VER = 12'h102;
  localparam logic [11:0] CSAAH_OFS_UNC_STS = 12'h104;
  localparam logic [11:0] CSAAH_OFS_UNC_MSK = 12'h108;
  localparam logic [11:0] CSAAH_OFS_UNC_SEV = 12'h10c;
  localparam logic [11:0] CSAAH_OFS_COR_STS = 12'h110;
  localparam logic [11:0] CSAAH_OFS_COR_MSK = 12'h114;
  localparam logic [11:0] CSAAH_OFS_ADV_CTL = 12'h118;
  localparam logic [11:0] CSAAH_OFS_HDR_LAST = 12'h128;
  localparam logic [11:0] CSAAH_OFS_SEC_STS = 12'h12c;
  localparam logic [11:0] CSAAH_OFS_SEC_MSK = 12'h130;
  localparam logic [11:0] CSAAH_OFS_SEC_SEV = 12'h134;
  localparam logic [11:0] CSAAH_OFS_SEC_CTL = 12'h138;
  localparam logic [11:0] CSAAH_OFS_SEC_HDR = 12'h13c;
  localparam logic [11:0] CSAAH_OFS_RSVD_LO = 12'h14c;
  localparam logic [11:0] CSAAH_OFS_RSVD_HI = 12'hffc;
  localparam int unsigned CSAAH_ARB_LINES = 6;
  localparam int unsigned CSAAH_ARB_BYTE_POS = 16;
  localparam int unsigned CSAAH_VRSV_B_POS = 16;
  localparam logic [5:0] CSAAH_ARB_FLAGS_RST = 6'h00;
  localparam logic [7:0] CSAAH_VRSV_A_RST = 8'h00;
  localparam logic [15:0] CSAAH_VRSV_B_RST = 16'h0000;
  localparam logic [15:0] CSAAH_VRSV_C_RST = 16'h0000;
  localparam logic [31:0] CSAAH_ERR_RST = 32'h0000_0000;
  localparam logic [15:0] CSAAH_CAP_ID_VAL = 16'h0001;
  localparam logic [11:0] CSAAH_NEXT_PTR_VAL = 12'h000;
  localparam logic [3:0] CSAAH_CAP_VER_VAL = 4'h1;
endpackage

/* csaah_regs.sv */
// Configuration register logic: arbiter time-out flags, vendor-reserved bytes,
// reset-class generation and the advanced error reporting header and registers.
// Assumes dword-wide configuration accesses with byte enables from the PCIe core,
// time-out pulses from the secondary arbiter on clk_i, and reset pins from outside.
//
// Notes on behaviour
// - Arbiter time-out pulse for a request line sets that line's flag.
// - Status byte bits 0..5 hold request lines 0..5; 1 means time-out seen.
// - Status byte bits 7 and 6 always read zero.
// - Flags set by hardware, cleared by software, reset to zero, at byte DEh.
// - Vendor byte at E0h resets to 00h only on fundamental reset.
// - Vendor halfword at E2h, read/write, resets to 0000h only on fundamental reset.
// - Vendor halfword at E4h, read/clear, defaults to 0000h.
// - Sticky class clears only on global reset or power-on reset.
// - EEPROM-loadable class clears on PCIe reset, global or power-on, not hot reset.
// - Remaining bits clear on hot reset, PCIe reset, global or power-on reset.
// - Error registers 104h..148h clear only on fundamental reset.
// - Internal fundamental reset is active low, asserted by PCIe or global reset.
// - Capability header at 100h, then error status, mask, severity, correctable regs.
// - Secondary status 12Ch, mask 130h, severity 134h, control 138h, log from 13Ch.
// - Halfword at 100h is read-only and returns 0001h.
// - Upper twelve bits at 102h read 000h, ending the capability list.
// - Low four bits at 102h read version 1h.
`timescale 1ns/1ns
module csaah_regs (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic global_reset_input_n_i,
  input wire logic perst_n_i,
  input wire logic hot_reset_i,
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic [csaah_pkg::CSAAH_ADDR_W-1:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [csaah_pkg::CSAAH_ARB_LINES-1:0] arb_timeout_i,
  input wire logic [31:0] unc_err_event_i,
  input wire logic [31:0] cor_err_event_i,
  input wire logic [31:0] sec_err_event_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  output logic fundamental_reset_internal_n_o,
  output logic sticky_reset_o,
  output logic eeprom_reset_o,
  output logic hot_class_reset_o,
  output logic [csaah_pkg::CSAAH_ARB_LINES-1:0] arb_flags_o
);
  import csaah_pkg::*;

  typedef struct packed {
    logic glob_meta;
    logic glob_sync;
    logic perst_meta;
    logic perst_sync;
    logic hot_meta;
    logic hot_sync;
    logic fund_n;
    logic sticky_rst;
    logic eeprom_rst;
    logic hot_rst;
    logic [5:0] arb_flags;
    logic [7:0] vrsv_a;
    logic [15:0] vrsv_b;
    logic [15:0] vrsv_c;
    logic [31:0] unc_sts;
    logic [31:0] unc_msk;
    logic [31:0] unc_sev;
    logic [31:0] cor_sts;
    logic [31:0] cor_msk;
    logic [31:0] adv_ctl;
    logic [31:0] sec_sts;
    logic [31:0] sec_msk;
    logic [31:0] sec_sev;
    logic [31:0] sec_ctl;
    logic [31:0] rdata;
    logic ack;
  } csaah_state_t;

  csaah_state_t st_r;
  csaah_state_t st_nxt;

  logic [11:0] dw_addr;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] w1c;
  logic [31:0] rd;
  logic fund_now;
  logic glob_now;

  assign dw_addr = {cfg_addr_i[11:2], 2'b00};
  assign wr = cfg_req_i & cfg_we_i;
  assign wmask = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
  assign w1c = cfg_wdata_i & wmask;

  always_comb begin
    st_nxt = st_r;
    rd = 32'h0000_0000;
    // Pins are two-stage synchronised; only the second stage is used below
    st_nxt.glob_meta = global_reset_input_n_i;
    st_nxt.glob_sync = st_r.glob_meta;
    st_nxt.perst_meta = perst_n_i;
    st_nxt.perst_sync = st_r.perst_meta;
    st_nxt.hot_meta = hot_reset_i;
    st_nxt.hot_sync = st_r.hot_meta;
    glob_now = ~st_r.glob_sync;
    fund_now = ~st_r.glob_sync | ~st_r.perst_sync;
    st_nxt.fund_n = ~fund_now;
    st_nxt.sticky_rst = glob_now;
    st_nxt.eeprom_rst = fund_now;
    st_nxt.hot_rst = fund_now | st_r.hot_sync;

    // Read mux; unmapped and reserved offsets answer zero
    unique case (dw_addr)
      {CSAAH_OFS_ARB_FLAGS[11:2], 2'b00}: rd[CSAAH_ARB_BYTE_POS +: 8] = {2'b00, st_r.arb_flags};
      CSAAH_OFS_VRSV_A: rd = {st_r.vrsv_b, 8'h00, st_r.vrsv_a};
      CSAAH_OFS_VRSV_C: rd = {16'h0000, st_r.vrsv_c};
      CSAAH_OFS_CAP_ID: rd = {CSAAH_NEXT_PTR_VAL, CSAAH_CAP_VER_VAL, CSAAH_CAP_ID_VAL};
      CSAAH_OFS_UNC_STS: rd = st_r.unc_sts;
      CSAAH_OFS_UNC_MSK: rd = st_r.unc_msk;
      CSAAH_OFS_UNC_SEV: rd = st_r.unc_sev;
      CSAAH_OFS_COR_STS: rd = st_r.cor_sts;
      CSAAH_OFS_COR_MSK: rd = st_r.cor_msk;
      CSAAH_OFS_ADV_CTL: rd = st_r.adv_ctl;
      CSAAH_OFS_SEC_STS: rd = st_r.sec_sts;
      CSAAH_OFS_SEC_MSK: rd = st_r.sec_msk;
      CSAAH_OFS_SEC_SEV: rd = st_r.sec_sev;
      CSAAH_OFS_SEC_CTL: rd = st_r.sec_ctl;
      // Header logs have no capture source here, so they read zero
      default: rd = 32'h0000_0000;
    endcase

    // Writes: byte-enabled; status fields are write-one-to-clear
    if (wr) begin
      unique case (dw_addr)
        {CSAAH_OFS_ARB_FLAGS[11:2], 2'b00}: st_nxt.arb_flags = st_r.arb_flags & ~w1c[CSAAH_ARB_BYTE_POS +: 6];
        CSAAH_OFS_VRSV_A: begin
          st_nxt.vrsv_a = (st_r.vrsv_a & ~wmask[7:0]) | (cfg_wdata_i[7:0] & wmask[7:0]);
          st_nxt.vrsv_b = (st_r.vrsv_b & ~wmask[31:16]) | (cfg_wdata_i[31:16] & wmask[31:16]);
        end
        CSAAH_OFS_VRSV_C: st_nxt.vrsv_c = st_r.vrsv_c & ~w1c[15:0];
        CSAAH_OFS_UNC_STS: st_nxt.unc_sts = st_r.unc_sts & ~w1c;
        CSAAH_OFS_UNC_MSK: st_nxt.unc_msk = (st_r.unc_msk & ~wmask) | w1c;
        CSAAH_OFS_UNC_SEV: st_nxt.unc_sev = (st_r.unc_sev & ~wmask) | w1c;
        CSAAH_OFS_COR_STS: st_nxt.cor_sts = st_r.cor_sts & ~w1c;
        CSAAH_OFS_COR_MSK: st_nxt.cor_msk = (st_r.cor_msk & ~wmask) | w1c;
        CSAAH_OFS_ADV_CTL: st_nxt.adv_ctl = (st_r.adv_ctl & ~wmask) | w1c;
        CSAAH_OFS_SEC_STS: st_nxt.sec_sts = st_r.sec_sts & ~w1c;
        CSAAH_OFS_SEC_MSK: st_nxt.sec_msk = (st_r.sec_msk & ~wmask) | w1c;
        CSAAH_OFS_SEC_SEV: st_nxt.sec_sev = (st_r.sec_sev & ~wmask) | w1c;
        CSAAH_OFS_SEC_CTL: st_nxt.sec_ctl = (st_r.sec_ctl & ~wmask) | w1c;
        default: st_nxt.ack = st_r.ack;
      endcase
    end

    // Hardware sets come after the clear so a same-cycle event is kept
    st_nxt.arb_flags = st_nxt.arb_flags | arb_timeout_i;
    st_nxt.unc_sts = st_nxt.unc_sts | (unc_err_event_i & ~st_r.unc_msk);
    st_nxt.cor_sts = st_nxt.cor_sts | (cor_err_event_i & ~st_r.cor_msk);
    st_nxt.sec_sts = st_nxt.sec_sts | (sec_err_event_i & ~st_r.sec_msk);

    // Reset classes, applied from the registered class strobes
    if (st_r.hot_rst) begin
      st_nxt.arb_flags = CSAAH_ARB_FLAGS_RST;
      st_nxt.vrsv_c = CSAAH_VRSV_C_RST;
    end
    // Fundamental-only registers deliberately ignore hot reset
    if (st_r.eeprom_rst) begin
      st_nxt.vrsv_a = CSAAH_VRSV_A_RST;
      st_nxt.vrsv_b = CSAAH_VRSV_B_RST;
      st_nxt.unc_sts = CSAAH_ERR_RST;
      st_nxt.unc_msk = CSAAH_ERR_RST;
      st_nxt.unc_sev = CSAAH_ERR_RST;
      st_nxt.cor_sts = CSAAH_ERR_RST;
      st_nxt.cor_msk = CSAAH_ERR_RST;
      st_nxt.adv_ctl = CSAAH_ERR_RST;
      st_nxt.sec_sts = CSAAH_ERR_RST;
      st_nxt.sec_msk = CSAAH_ERR_RST;
      st_nxt.sec_sev = CSAAH_ERR_RST;
      st_nxt.sec_ctl = CSAAH_ERR_RST;
    end

    st_nxt.ack = cfg_req_i;
    st_nxt.rdata = (cfg_req_i & ~cfg_we_i) ? rd : 32'h0000_0000;
  end

  // Power-on reset puts every register, sync stages included, to its default
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_rdata_o = st_r.rdata;
  assign cfg_ack_o = st_r.ack;
  assign fundamental_reset_internal_n_o = st_r.fund_n;
  assign sticky_reset_o = st_r.sticky_rst;
  assign eeprom_reset_o = st_r.eeprom_rst;
  assign hot_class_reset_o = st_r.hot_rst;
  assign arb_flags_o = st_r.arb_flags;
endmodule // csaah_regs

/* csaah_regs_chk.sv */
// Port checker for csaah_regs.
// Assumes one clock domain and sys_rst_i asynchronous, active high.
`timescale 1ns/1ns
module csaah_regs_chk import csaah_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic global_reset_input_n_i,
  input wire logic perst_n_i,
  input wire logic hot_reset_i,
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic cfg_ack_o,
  input wire logic fundamental_reset_internal_n_o,
  input wire logic sticky_reset_o,
  input wire logic eeprom_reset_o,
  input wire logic hot_class_reset_o,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic [5:0] arb_timeout_i,
  input wire logic [5:0] arb_flags_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic rd_req = cfg_req_i && !cfg_we_i;
  wire logic flag_dw = cfg_addr_i[11:2] == 10'h037;
  wire logic [5:0] w1c_bits = cfg_wdata_i[21:16];
  a_ack_next: assert property (cfg_req_i |=> cfg_ack_o)
    else $error("ack missing after request");
  a_ack_cause: assert property (cfg_ack_o |-> $past(cfg_req_i))
    else $error("ack without request");
  a_idle_zero: assert property (!cfg_ack_o |-> cfg_rdata_o == 32'h0)
    else $error("read data not zero when idle");
  a_cap_header: assert property (rd_req && cfg_addr_i[11:2] == 10'h040 |=> cfg_rdata_o == 32'h0001_0001)
    else $error("capability header wrong");
  a_rsvd_zero: assert property (rd_req && cfg_addr_i >= CSAAH_OFS_RSVD_LO |=> cfg_rdata_o == 32'h0)
    else $error("reserved space not zero");
  a_flag_layout: assert property (rd_req && flag_dw |=> cfg_rdata_o[23:16] == {2'b00, $past(arb_flags_o)})
    else $error("flag byte layout wrong");
  a_flag_set: assert property (|arb_timeout_i && !hot_class_reset_o |=>
    (arb_flags_o & $past(arb_timeout_i)) == $past(arb_timeout_i)) else $error("time-out flag not set");
  a_w1c_only: assert property (cfg_req_i && cfg_we_i && flag_dw && cfg_be_i[2] && arb_timeout_i == 6'h0
    && !hot_class_reset_o |=> arb_flags_o == ($past(arb_flags_o) & ~$past(w1c_bits))) else $error("flag clear wrong");
  a_perst_class: assert property (!perst_n_i [*4] |-> !fundamental_reset_internal_n_o && eeprom_reset_o)
    else $error("pcie reset class wrong");
  a_glob_class: assert property (!global_reset_input_n_i [*4] |-> sticky_reset_o && !fundamental_reset_internal_n_o)
    else $error("global reset class wrong");
  a_sticky_keep: assert property ((!perst_n_i && global_reset_input_n_i) [*4] |-> !sticky_reset_o)
    else $error("sticky class hit by pcie reset");
  a_hot_class: assert property ((hot_reset_i && perst_n_i && global_reset_input_n_i) [*6]
    |-> hot_class_reset_o && !eeprom_reset_o && fundamental_reset_internal_n_o) else $error("hot reset class wrong");
  c_cap_read: cover property (rd_req && cfg_addr_i[11:2] == 10'h040);
  c_timeout: cover property (|arb_timeout_i);
  c_hot: cover property (hot_reset_i [*4]);
endmodule // csaah_regs_chk
bind csaah_regs csaah_regs_chk u_chk (.clk_i, .sys_rst_i, .global_reset_input_n_i, .perst_n_i, .hot_reset_i,
  .cfg_req_i, .cfg_we_i, .cfg_ack_o, .fundamental_reset_internal_n_o, .sticky_reset_o, .eeprom_reset_o,
  .hot_class_reset_o, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o, .arb_timeout_i, .arb_flags_o);

/* csaah_regs_test.sv */
// Self-checking bench for csaah_regs with the host model.
// Assumes a 20 MHz clock and inputs driven at the falling edge.
`timescale 1ns/1ns
module csaah_regs_test;
  import csaah_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, glob_n = 1, perst_n = 1, hot = 0, req, we, ack;
  logic [5:0] tmo = 0;
  logic [31:0] unc = 0, cor = 0, sec = 0, rdata, q, wdata;
  logic [11:0] addr;
  logic [3:0] be;
  int err_count = 0, check_count = 0;
  always #25 clk_i = ~clk_i;
  csaah_host host (.clk_i, .ack_i(ack), .rdata_i(rdata), .req_o(req), .we_o(we), .addr_o(addr), .be_o(be),
    .wdata_o(wdata));
  csaah_regs dut (.clk_i, .sys_rst_i, .global_reset_input_n_i(glob_n), .perst_n_i(perst_n), .hot_reset_i(hot),
    .cfg_req_i(req), .cfg_we_i(we), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata), .arb_timeout_i(tmo),
    .unc_err_event_i(unc), .cor_err_event_i(cor), .sec_err_event_i(sec), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
    .fundamental_reset_internal_n_o(), .sticky_reset_o(), .eeprom_reset_o(), .hot_class_reset_o(),
    .arb_flags_o());
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(string n, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task rd(logic [11:0] a, logic [31:0] exp, string n);
    host.xfer(1'b0, a, 4'h0, 32'h0, q);
    chk(n, q, exp);
  endtask
  task wr(logic [11:0] a, logic [3:0] b, logic [31:0] d);
    host.xfer(1'b1, a, b, d, q);
  endtask
  task pulse(logic [5:0] t, logic [31:0] u, logic [31:0] c, logic [31:0] s);
    @(negedge clk_i) {tmo, unc, cor, sec} = {t, u, c, s};
    @(negedge clk_i) {tmo, unc, cor, sec} = '0;
  endtask
  // Pin k: 0 hot reset, 1 pcie reset, 2 global reset; long enough for the synchronisers
  task pin(int k);
    @(negedge clk_i) {hot, perst_n, glob_n} = {k == 0, k != 1, k != 2};
    repeat (6) @(negedge clk_i);
    {hot, perst_n, glob_n} = 3'b011;
    repeat (8) @(negedge clk_i);
  endtask
  task t_defaults;
    rd(12'h0dc, 32'h0, "flags");
    rd(12'h0e0, 32'h0, "vendor a b");
    rd(12'h0e4, 32'h0, "vendor c");
    wr(12'h100, 4'hf, 32'hffff_ffff);
    rd(12'h100, 32'h0001_0001, "cap header");
    $display("t_defaults done");
  endtask
  task t_flags;
    pulse(6'h2d, 0, 0, 0);
    rd(12'h0dc, 32'h002d_0000, "flags set");
    wr(12'h0dc, 4'b0100, 32'hffe1_ffff);
    rd(12'h0dc, 32'h000c_0000, "flags cleared");
    pin(0);
    rd(12'h0dc, 32'h0, "flags hot");
    $display("t_flags done");
  endtask
  task t_errors;
    wr(12'h0e0, 4'b1101, 32'h5a3c_7796);
    rd(12'h0e0, 32'h5a3c_0096, "vendor write");
    wr(12'h108, 4'hf, 32'h10);
    wr(12'h130, 4'hf, 32'h1);
    pulse(0, 32'h1010, 32'h40, 32'h3);
    rd(12'h104, 32'h1000, "fatal flags");
    rd(12'h110, 32'h40, "recoverable");
    rd(12'h12c, 32'h2, "secondary");
    pin(0);
    rd(12'h104, 32'h1000, "fatal hot");
    rd(12'h0e0, 32'h5a3c_0096, "vendor hot");
    pin(1);
    rd(12'h0e0, 32'h0, "vendor perst");
    rd(12'h104, 32'h0, "fatal perst");
    wr(12'h108, 4'hf, 32'h10);
    pin(2);
    rd(12'h108, 32'h0, "mask global");
    $display("t_errors done");
  endtask
  task t_reserved;
    wr(12'h14c, 4'hf, 32'hffff_ffff);
    rd(12'h14c, 32'h0, "reserved low");
    rd(12'hffc, 32'h0, "reserved high");
    rd(12'h13c, 32'h0, "secondary log");
    $display("t_reserved done");
  endtask
  initial begin
    repeat (20) @(negedge clk_i);
    sys_rst_i = 0;
    repeat (8) @(negedge clk_i);
    t_defaults;
    t_flags;
    t_errors;
    t_reserved;
    report_and_stop;
  end
  initial begin
    #1000000;
    err_count++;
    report_and_stop;
  end
endmodule // csaah_regs_test
